// *** logic/adc_ctl_params.svh ***
// Register map, field positions, reset values and timing counts
// ============================================================
// Behaviour
// - Successive approximation to 12-bit result
// - Reserved channel still converts, result undefined
// - Unimplemented channel numbers are reserved
// - Continuous long-sample conversion within 40 ticks
// - Clock from selected source, then divided
// - Single 10-bit: 23 ticks plus 5 cycles
// - Compare adds result to negated compare value
// - Greater select: flag when result >= value
// - Less select: flag when result < value
// - Met compare stores difference in results
// - Failed compare: no flag, results unchanged
// - Interrupt when flag sets with enable
// - Compare works in wait, and in stop3 on the async clock only, wakes core
// - Running conversion finishes in wait mode, except on the alternate clock, which is held off
// - Wait mode accepts trigger and continuous starts
// - Bus, half bus, async clocks usable in wait
`ifndef ADC_CTL_PARAMS_SVH
`define ADC_CTL_PARAMS_SVH

// ============================================================
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_CLKCFG 8'h04
`define REG_CHAN 8'h08
`define REG_STATUS 8'h0c
`define REG_RESULT_HIGH 8'h10
`define REG_RESULT_LOW 8'h14
`define REG_COMPARE_HIGH 8'h18
`define REG_COMPARE_LOW 8'h1c
`define REG_INT_STATUS 8'h20
`define REG_INT_MASK 8'h24

// ============================================================
// Field positions
`define CTRL_CMP_EN 0
`define CTRL_CMP_GT 1
`define CTRL_CONV_INTERRUPT_ENABLE 2
`define CTRL_CONT 3
`define CTRL_LSMP 4
`define CTRL_MODE_LO 5
`define CTRL_HWTRG 7
`define INT_DONE 0
`define INT_WAKE 1

// ============================================================
// Reset values
`define CTRL_RESET 8'h00
`define CLKCFG_RESET 4'h0
`define CHAN_RESET 5'h00
`define INT_MASK_RESET 2'h0

// ============================================================
// Timing counts
`define OVERHEAD_BUS_CYC 5'h05
`define SAMPLE_SHORT_TICKS 5'h0c
`define SAMPLE_LONG_TICKS 5'h1a
`define CONT_LIMIT_TICKS 6'h28
`define SINGLE_TEN_BIT_AGE 6'h1b

`endif

// *** logic/adc_ctl_pkg.sv ***
// Types shared by the converter control logic
package adc_ctl_pkg;
   typedef enum logic [1:0] {
      SRC_BUS = 2'h0,
      SRC_HALF = 2'h1,
      SRC_ALT = 2'h2,
      SRC_ASYNC = 2'h3
   } clk_src_e;

   typedef enum logic [1:0] {
      MODE_8 = 2'h0,
      MODE_12 = 2'h1,
      MODE_10 = 2'h2,
      MODE_RSV = 2'h3
   } res_mode_e;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_OVERHEAD = 5'b00010,
      ST_SAMPLE = 5'b00100,
      ST_CONVERT = 5'b01000,
      ST_FINISH = 5'b10000
   } conv_state_e;
endpackage

// *** logic/sar_adc_ctl.sv ***
// Successive-approximation converter control with APB registers
`timescale 1ns/1ns
`include "adc_ctl_params.svh"

module sar_adc_ctl #(
   parameter int CHANNELS = 16
) (
   input wire logic clk, // Bus clock, 100 MHz
   input wire logic srst, // Synchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic alternateClock, // Alternate clock, foreign domain
   input wire logic asyncConvClock, // Dedicated async clock
   input wire logic hwTrigger, // Hardware start, foreign domain
   input wire logic waitMode, // Core in wait mode, same clock
   input wire logic stop3Mode, // Core in stop3 mode, same clock
   input wire logic cmpHigh, // Front end: sample >= dacCode
   output logic [11:0] dacCode, // Trial code to front end
   output logic [4:0] chanSel, // Channel to multiplexer
   output logic [1:0] resMode, // Result width to front end
   output logic sampling, // Front end tracks input
   output logic irq, // Level interrupt
   output logic wakeReq // Wake request in low-power modes
);

   // ============================================================
   // Parameter check
   if (CHANNELS < 1 || CHANNELS > 32) begin : g_bad_channels
      $error("CHANNELS must lie between 1 and 32");
   end

   // ============================================================
   // Registers and state
   logic [7:0] ctrl_r;
   logic [3:0] clkCfg_r;
   logic [4:0] chan_r;
   logic [3:0] cmpValHigh_r;
   logic [7:0] cmpValLow_r;
   logic [3:0] resultHigh_r;
   logic [7:0] resultLow_r;
   logic [1:0] intStatus_r;
   logic [1:0] intMask_r;
   logic conversion_complete_flag_r;
   logic [31:0] rdData_r;
   logic slvErr_r;
   adc_ctl_pkg::conv_state_e state_r;
   logic [4:0] phaseCnt_r;
   logic [11:0] bitMask_r;
   logic [11:0] trial_r;
   logic halfTog_r;
   logic [2:0] divCnt_r;
   logic [2:0] altSync_r;
   logic [2:0] asyncSync_r;
   logic [2:0] trigSync_r;

   // Decoded controls
   logic cmpEn, cmpGt, conv_interrupt_enable, contEn, longSmp, hwTrgEn;
   adc_ctl_pkg::clk_src_e srcSel;
   adc_ctl_pkg::res_mode_e mode;
   logic setupPh, accessPh, wrAcc, rdAcc, mapped;
   logic chanWrite, resLowRead, trigEdge, startReq;
   logic srcTick, divTick, doneNow, cocoSet, lowPower;
   logic [2:0] divMax;
   logic [11:0] resMask, msbMask, cmpVal, decided;
   logic [12:0] diff;
   logic cmpOk;
   logic [4:0] sampleTicks;

   assign cmpEn = ctrl_r[`CTRL_CMP_EN];
   assign cmpGt = ctrl_r[`CTRL_CMP_GT];
   assign conv_interrupt_enable = ctrl_r[`CTRL_CONV_INTERRUPT_ENABLE];
   assign contEn = ctrl_r[`CTRL_CONT];
   assign longSmp = ctrl_r[`CTRL_LSMP];
   assign hwTrgEn = ctrl_r[`CTRL_HWTRG];
   assign srcSel = adc_ctl_pkg::clk_src_e'(clkCfg_r[1:0]);
   assign mode = adc_ctl_pkg::res_mode_e'(ctrl_r[`CTRL_MODE_LO +: 2]);
   assign lowPower = waitMode | stop3Mode;

   // ============================================================
   // APB slave: read data captured in setup, write data in access, zero wait states
   assign setupPh = psel & ~penable;
   assign accessPh = psel & penable;
   assign wrAcc = accessPh & pwrite & ~slvErr_r;
   assign rdAcc = accessPh & ~pwrite & ~slvErr_r;
   assign pready = accessPh;
   assign prdata = rdData_r;
   assign pslverr = slvErr_r & accessPh;
   assign chanWrite = wrAcc & (paddr == `REG_CHAN);
   assign resLowRead = rdAcc & (paddr == `REG_RESULT_LOW);

   // Address decode for the error answer
   always_comb begin
      unique case (paddr)
         `REG_CTRL, `REG_CLKCFG, `REG_CHAN, `REG_STATUS,
         `REG_RESULT_HIGH, `REG_RESULT_LOW, `REG_COMPARE_HIGH,
         `REG_COMPARE_LOW, `REG_INT_STATUS, `REG_INT_MASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Read data and error flag latched in the setup cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         rdData_r <= 32'h0;
         slvErr_r <= 1'b0;
      end else if (setupPh) begin
         slvErr_r <= ~mapped;
         unique case (paddr)
            `REG_CTRL: rdData_r <= {24'h0, ctrl_r};
            `REG_CLKCFG: rdData_r <= {28'h0, clkCfg_r};
            `REG_CHAN: rdData_r <= {27'h0, chan_r};
            `REG_STATUS: rdData_r <= {29'h0,
               (32'(chan_r) >= CHANNELS),
               state_r != adc_ctl_pkg::ST_IDLE, conversion_complete_flag_r};
            `REG_RESULT_HIGH: rdData_r <= {28'h0, resultHigh_r};
            `REG_RESULT_LOW: rdData_r <= {24'h0, resultLow_r};
            `REG_COMPARE_HIGH: rdData_r <= {28'h0, cmpValHigh_r};
            `REG_COMPARE_LOW: rdData_r <= {24'h0, cmpValLow_r};
            `REG_INT_STATUS: rdData_r <= {30'h0, intStatus_r};
            `REG_INT_MASK: rdData_r <= {30'h0, intMask_r};
            default: rdData_r <= 32'h0;
         endcase
      end
   end

   // Software-written configuration
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_r <= `CTRL_RESET;
         clkCfg_r <= `CLKCFG_RESET;
         chan_r <= `CHAN_RESET;
         cmpValHigh_r <= 4'h0;
         cmpValLow_r <= 8'h00;
         intMask_r <= `INT_MASK_RESET;
      end else if (wrAcc) begin
         unique case (paddr)
            `REG_CTRL: ctrl_r <= pwdata[7:0];
            `REG_CLKCFG: clkCfg_r <= pwdata[3:0];
            `REG_CHAN: chan_r <= pwdata[4:0];
            `REG_COMPARE_HIGH: cmpValHigh_r <= pwdata[3:0];
            `REG_COMPARE_LOW: cmpValLow_r <= pwdata[7:0];
            `REG_INT_MASK: intMask_r <= pwdata[1:0];
            default: ;
         endcase
      end
   end

   // ============================================================
   // Clock sources; foreign inputs pass two flops before use
   always_ff @(posedge clk) begin
      if (srst) begin
         altSync_r <= 3'h0;
         asyncSync_r <= 3'h0;
         trigSync_r <= 3'h0;
         halfTog_r <= 1'b0;
      end else begin
         altSync_r <= {altSync_r[1:0], alternateClock};
         asyncSync_r <= {asyncSync_r[1:0], asyncConvClock};
         trigSync_r <= {trigSync_r[1:0], hwTrigger};
         halfTog_r <= ~halfTog_r;
      end
   end

   assign trigEdge = trigSync_r[1] & ~trigSync_r[2];

   // Source select; in wait the alternate clock is held off
   always_comb begin
      unique case (srcSel)
         adc_ctl_pkg::SRC_BUS: srcTick = ~stop3Mode;
         adc_ctl_pkg::SRC_HALF: srcTick = halfTog_r & ~stop3Mode;
         adc_ctl_pkg::SRC_ALT:
            srcTick = altSync_r[1] & ~altSync_r[2] & ~lowPower;
         adc_ctl_pkg::SRC_ASYNC:
            srcTick = asyncSync_r[1] & ~asyncSync_r[2];
      endcase
   end

   // Divider ratio 1, 2, 4 or 8
   always_comb begin
      unique case (clkCfg_r[3:2])
         2'h0: divMax = 3'h0;
         2'h1: divMax = 3'h1;
         2'h2: divMax = 3'h3;
         2'h3: divMax = 3'h7;
      endcase
   end

   assign divTick = srcTick & (divCnt_r == divMax);

   // Divider counter advances on source ticks only
   always_ff @(posedge clk) begin
      if (srst) begin
         divCnt_r <= 3'h0;
      end else if (srcTick) begin
         divCnt_r <= divTick ? 3'h0 : divCnt_r + 3'h1;
      end
   end

   // ============================================================
   // Conversion sequencer
   // With hardware trigger off, a channel write restarts even a running conversion; triggers
   // are taken whatever the power mode, so wait mode never blocks them
   assign startReq = hwTrgEn ? (trigEdge & (state_r ==
      adc_ctl_pkg::ST_IDLE)) : chanWrite;
   assign sampleTicks = longSmp ? `SAMPLE_LONG_TICKS
      : `SAMPLE_SHORT_TICKS;
   assign decided = cmpHigh ? trial_r : (trial_r & ~bitMask_r);

   // Width-dependent masks
   always_comb begin
      unique case (mode)
         adc_ctl_pkg::MODE_8: begin
            resMask = 12'h0ff;
            msbMask = 12'h080;
         end
         adc_ctl_pkg::MODE_10: begin
            resMask = 12'h3ff;
            msbMask = 12'h200;
         end
         default: begin
            resMask = 12'hfff;
            msbMask = 12'h800;
         end
      endcase
   end

   // State walk; wait mode has no branch here, so work runs on
   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= adc_ctl_pkg::ST_IDLE;
         phaseCnt_r <= 5'h00;
         bitMask_r <= 12'h000;
         trial_r <= 12'h000;
      end else if (startReq) begin
         state_r <= adc_ctl_pkg::ST_OVERHEAD;
         phaseCnt_r <= `OVERHEAD_BUS_CYC - 5'h01;
      end else begin
         unique case (state_r)
            adc_ctl_pkg::ST_IDLE: ;
            adc_ctl_pkg::ST_OVERHEAD: begin
               if (phaseCnt_r == 5'h00) begin
                  state_r <= adc_ctl_pkg::ST_SAMPLE;
                  phaseCnt_r <= sampleTicks - 5'h01;
               end else begin
                  phaseCnt_r <= phaseCnt_r - 5'h01;
               end
            end
            adc_ctl_pkg::ST_SAMPLE: begin
               if (divTick && phaseCnt_r == 5'h00) begin
                  state_r <= adc_ctl_pkg::ST_CONVERT;
                  bitMask_r <= msbMask;
                  trial_r <= msbMask;
               end else if (divTick) begin
                  phaseCnt_r <= phaseCnt_r - 5'h01;
               end
            end
            adc_ctl_pkg::ST_CONVERT: begin
               if (divTick) begin
                  trial_r <= decided | (bitMask_r >> 1);
                  bitMask_r <= bitMask_r >> 1;
                  if (bitMask_r[0]) begin
                     state_r <= adc_ctl_pkg::ST_FINISH;
                  end
               end
            end
            adc_ctl_pkg::ST_FINISH: begin
               if (divTick && contEn) begin
                  state_r <= adc_ctl_pkg::ST_SAMPLE;
                  phaseCnt_r <= sampleTicks - 5'h01;
               end else if (divTick) begin
                  state_r <= adc_ctl_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // ============================================================
   // Completion and compare
   assign doneNow = (state_r == adc_ctl_pkg::ST_FINISH) & divTick;
   assign cmpVal = {cmpValHigh_r, cmpValLow_r} & resMask;
   assign diff = {1'b0, trial_r} + {1'b0, ~cmpVal} + 13'h0001;
   assign cmpOk = cmpGt ? diff[12] : ~diff[12];
   assign cocoSet = doneNow & (~cmpEn | cmpOk);

   // Result transfer only when the flag is set
   always_ff @(posedge clk) begin
      if (srst) begin
         resultHigh_r <= 4'h0;
         resultLow_r <= 8'h00;
      end else if (cocoSet && cmpEn) begin
         {resultHigh_r, resultLow_r} <= diff[11:0] & resMask;
      end else if (cocoSet) begin
         {resultHigh_r, resultLow_r} <= trial_r;
      end
   end

   // Flag clears on channel write or low result read; set wins
   always_ff @(posedge clk) begin
      if (srst) begin
         conversion_complete_flag_r <= 1'b0;
      end else if (cocoSet) begin
         conversion_complete_flag_r <= 1'b1;
      end else if (chanWrite || resLowRead) begin
         conversion_complete_flag_r <= 1'b0;
      end
   end

   // ============================================================
   // Interrupt status, write one to clear, set wins
   always_ff @(posedge clk) begin
      if (srst) begin
         intStatus_r <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == `INT_DONE && cocoSet && conv_interrupt_enable) ||
                (i == `INT_WAKE && cocoSet && cmpEn && lowPower))
               intStatus_r[i] <= 1'b1;
            else if (wrAcc && paddr == `REG_INT_STATUS && pwdata[i])
               intStatus_r[i] <= 1'b0;
         end
      end
   end

   assign irq = |(intStatus_r & intMask_r);
   assign wakeReq = irq & lowPower;

   // Front-end drive
   assign dacCode = trial_r;
   assign chanSel = chan_r;
   assign resMode = ctrl_r[`CTRL_MODE_LO +: 2];
   assign sampling = (state_r == adc_ctl_pkg::ST_SAMPLE);

   // ============================================================
   // Checks; helper counters measure conversion length
   logic [5:0] startAge_r;
   logic [5:0] contAge_r;
   logic firstRun_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         startAge_r <= 6'h00;
         contAge_r <= 6'h00;
         firstRun_r <= 1'b0;
      end else begin
         startAge_r <= startReq ? 6'h00
            : (startAge_r == 6'h3f ? startAge_r : startAge_r + 6'h01);
         if (doneNow || startReq)
            contAge_r <= 6'h00;
         else if (divTick && contAge_r != 6'h3f)
            contAge_r <= contAge_r + 6'h01;
         if (startReq)
            firstRun_r <= 1'b1;
         else if (doneNow)
            firstRun_r <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence doneCmpFail;
      doneNow && cmpEn && !cmpOk && !startReq;
   endsequence

   sequence resultsHeld;
      $stable(resultHigh_r) && $stable(resultLow_r);
   endsequence

   chk_fail_no_flag: assert property (
      doneCmpFail ##0 !conversion_complete_flag_r |=> !conversion_complete_flag_r ##0 resultsHeld)
      else $error("failed compare changed flag or results");
   chk_upper_limit: assert property (
      doneNow && cmpEn && cmpGt && diff[12] |=> conversion_complete_flag_r)
      else $error("upper limit met but flag clear");
   chk_lower_limit: assert property (
      doneNow && cmpEn && !cmpGt |=> conversion_complete_flag_r == !$past(diff[12]))
      else $error("lower limit flag wrong");
   chk_diff_stored: assert property (
      cocoSet && cmpEn |=> {resultHigh_r, resultLow_r} ==
         ($past(diff[11:0]) & $past(resMask)))
      else $error("stored difference wrong");
   chk_plain_done: assert property (
      doneNow && !cmpEn |=> conversion_complete_flag_r &&
         {resultHigh_r, resultLow_r} == $past(trial_r))
      else $error("plain conversion not stored");
   chk_irq_raise: assert property (
      cocoSet && conv_interrupt_enable && intMask_r[`INT_DONE] |=> irq [*2])
      else $error("interrupt not raised after flag");
   chk_single_time: assert property (
      doneNow && firstRun_r && srcSel == adc_ctl_pkg::SRC_BUS &&
      clkCfg_r[3:2] == 2'h0 && !longSmp &&
      mode == adc_ctl_pkg::MODE_10 |-> startAge_r == `SINGLE_TEN_BIT_AGE)
      else $error("single conversion length wrong");
   chk_cont_limit: assert property (
      doneNow && !firstRun_r && longSmp |-> contAge_r < `CONT_LIMIT_TICKS)
      else $error("continuous conversion too long");
   chk_wait_finish: assert property (
      state_r == adc_ctl_pkg::ST_CONVERT && waitMode && !startReq
      |=> state_r != adc_ctl_pkg::ST_IDLE)
      else $error("conversion dropped in wait");
   chk_wait_trigger: assert property (
      hwTrgEn && trigEdge && waitMode && state_r == adc_ctl_pkg::ST_IDLE
      |=> state_r == adc_ctl_pkg::ST_OVERHEAD)
      else $error("trigger ignored in wait");
   chk_stop_wake: assert property (
      cocoSet && cmpEn && stop3Mode && intMask_r[`INT_WAKE]
      |=> ##[0:1] wakeReq)
      else $error("compare match did not wake core");

endmodule

// *** verification/analog_front_end.sv ***
// Behavioural sampling front end and channel multiplexer model
`timescale 1ns/1ns

module analog_front_end #(
   parameter int CHANNELS = 16
) (
   input wire logic clk, // Bus clock
   input wire logic [11:0] level, // Level on the selected channel
   input wire logic [11:0] dacCode, // Trial code from the control
   input wire logic [4:0] chanSel, // Selected channel
   input wire logic sampling, // Track phase
   output logic cmpHigh // Comparator answer
);
   logic [11:0] held_r = 12'h000;
   logic [11:0] noise_r = 12'h5a5;

   // Hold follows the input while tracking, then freezes for the bits
   always @(posedge clk) begin
      noise_r <= {noise_r[10:0], noise_r[11] ^ noise_r[5]};
      if (sampling) begin
         held_r <= level;
      end
   end

   // A reserved channel has no source, so its answer wanders every cycle
   assign cmpHigh = (chanSel >= CHANNELS) ? noise_r[0] : (held_r >= dacCode);
endmodule

// *** verification/sar_adc_ctl_tb_top.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`include "adc_ctl_params.svh"

module sar_adc_ctl_tb_top;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic alternateClock = 1'b0;
   logic asyncConvClock = 1'b0;
   logic hwTrigger = 1'b0;
   logic waitMode = 1'b0;
   logic stop3Mode = 1'b0;
   logic cmpHigh;
   logic [11:0] dacCode;
   logic [4:0] chanSel;
   logic [1:0] resMode;
   logic sampling;
   logic irq;
   logic wakeReq;
   logic [11:0] level = 12'h000;
   logic [31:0] rd;
   logic [31:0] lfsr = 32'hd552;
   logic lastErr;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   int accCyc = 0;

   // ============================================================
   // Clocks: slow sources are derived from the bus clock, so they stay phase-locked to it
   always #5 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc % 2 == 0) begin
         alternateClock <= ~alternateClock;
      end
      if (cyc % 3 == 0) begin
         asyncConvClock <= ~asyncConvClock;
      end
   end

   sar_adc_ctl i_sar_adc_ctl (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .alternateClock(alternateClock),
      .asyncConvClock(asyncConvClock), .hwTrigger(hwTrigger),
      .waitMode(waitMode), .stop3Mode(stop3Mode), .cmpHigh(cmpHigh),
      .dacCode(dacCode), .chanSel(chanSel), .resMode(resMode),
      .sampling(sampling), .irq(irq), .wakeReq(wakeReq)
   );

   analog_front_end i_analog_front_end (
      .clk(clk), .level(level), .dacCode(dacCode), .chanSel(chanSel),
      .sampling(sampling), .cmpHigh(cmpHigh)
   );

   // ============================================================
   // Helpers
   function automatic logic cmpMet(input logic [11:0] r,
                                   input logic [11:0] c, input logic g);
      return g ? (r >= c) : (r < c);
   endfunction

   function automatic void rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
   endfunction

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (fails == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // One APB transfer; holds the request until pready, then an idle edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      accCyc = cyc;
      rd = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Polls busy under a bound, then leaves the settled status in rd
   task automatic waitDone();
      int n;
      n = 0;
      rd = 32'h2;
      while (rd[1] !== 1'b0 && n < 1000) begin
         apb(1'b0, `REG_STATUS, 32'h0);
         n++;
      end
      apb(1'b0, `REG_STATUS, 32'h0);
   endtask

   task automatic waitIrq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
   endtask

   task automatic readRes(output logic [11:0] r);
      logic [3:0] h;
      apb(1'b0, `REG_RESULT_HIGH, 32'h0);
      h = rd[3:0];
      apb(1'b0, `REG_RESULT_LOW, 32'h0);
      r = {h, rd[7:0]};
   endtask

   // Watchdog sized well above the longest source and divider mix
   initial begin
      repeat (80000) @(posedge clk);
      fails++;
      end_of_test();
   end

   // ============================================================
   // Main sequence
   initial begin
      int t;
      logic [11:0] cv;
      logic [11:0] res;
      logic [11:0] got;
      logic g;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      // Every register word clears on reset; an unused word errors
      for (int a = 0; a < 10; a++) begin
         apb(1'b0, 8'(a * 4), 32'h0);
         check("reset value", rd, 32'h0);
      end
      apb(1'b0, 8'h3c, 32'h0);
      check("unmapped error", {31'h0, lastErr}, 32'h1);
      // Single 10-bit conversion on the undivided bus clock
      apb(1'b1, `REG_INT_MASK, 32'h1);
      apb(1'b1, `REG_CTRL, 32'h44);
      apb(1'b1, `REG_CHAN, 32'h0);
      t = accCyc;
      while (irq !== 1'b1 && cyc - t < 100) @(posedge clk);
      t = cyc - t;
      check("single time", {31'h0, t >= 29 && t <= 31}, 32'h1);
      apb(1'b1, `REG_INT_STATUS, 32'h1);
      check("irq clear", {31'h0, irq}, 32'h0);
      // Masked completion still records but keeps the line low
      apb(1'b1, `REG_INT_MASK, 32'h0);
      apb(1'b1, `REG_CHAN, 32'h0);
      waitDone();
      apb(1'b0, `REG_INT_STATUS, 32'h0);
      check("masked status", rd, 32'h1);
      check("masked irq", {31'h0, irq}, 32'h0);
      apb(1'b1, `REG_INT_STATUS, 32'h1);
      // Plain 12-bit conversions, a full-scale and a reserved channel
      apb(1'b1, `REG_CTRL, 32'h20);
      for (int i = 0; i < 6; i++) begin
         rnd();
         level <= (i == 0) ? 12'hfff : lfsr[11:0];
         apb(1'b1, `REG_CHAN, (i == 5) ? 32'h14 : 32'h3);
         check("channel out", {27'h0, chanSel}, (i == 5) ? 32'h14 : 32'h3);
         check("width out", {30'h0, resMode}, 32'h1);
         waitDone();
         check("sampling idle", {31'h0, sampling}, 32'h0);
         check("flag", {31'h0, rd[0]}, 32'h1);
         if (i == 5) begin
            check("reserved", {31'h0, rd[2]}, 32'h1);
         end
         readRes(res);
         if (i != 5) begin
            check("result", {20'h0, res}, {20'h0, level});
         end
      end
      // Compare both directions, equal values first
      for (int i = 0; i < 12; i++) begin
         g = i[0];
         rnd();
         cv = lfsr[23:12];
         level <= (i < 4) ? cv : lfsr[11:0];
         apb(1'b1, `REG_COMPARE_HIGH, {28'h0, cv[11:8]});
         apb(1'b1, `REG_COMPARE_LOW, {24'h0, cv[7:0]});
         apb(1'b1, `REG_CTRL, {30'h8, g, 1'b1});
         apb(1'b1, `REG_CHAN, 32'h2);
         waitDone();
         check("cmp flag", {31'h0, rd[0]}, {31'h0, cmpMet(level, cv, g)});
         if (cmpMet(level, cv, g)) begin
            res = level - cv;
         end
         readRes(got);
         check("cmp result", {20'h0, got}, {20'h0, res});
      end
      // Compare met in stop3 on the async source wakes the core
      apb(1'b1, `REG_CLKCFG, 32'h3);
      apb(1'b1, `REG_COMPARE_HIGH, 32'h0);
      apb(1'b1, `REG_COMPARE_LOW, 32'h0);
      apb(1'b1, `REG_INT_MASK, 32'h3);
      apb(1'b1, `REG_CTRL, 32'h27);
      stop3Mode <= 1'b1;
      apb(1'b1, `REG_CHAN, 32'h1);
      waitDone();
      check("wake", {31'h0, wakeReq}, 32'h1);
      apb(1'b0, `REG_INT_STATUS, 32'h0);
      check("wake status", rd, 32'h3);
      stop3Mode <= 1'b0;
      apb(1'b1, `REG_INT_STATUS, 32'h3);
      check("irq cleared", {31'h0, irq}, 32'h0);
      // Each source and a random divider; wait entered mid-conversion except on the alternate source
      apb(1'b1, `REG_CTRL, 32'h20);
      for (int s = 0; s < 4; s++) begin
         rnd();
         level <= lfsr[11:0];
         apb(1'b1, `REG_CLKCFG, {28'h0, lfsr[13:12], s[1:0]});
         apb(1'b1, `REG_CHAN, 32'h4);
         waitMode <= (s != 2);
         waitDone();
         readRes(got);
         check("wait result", {20'h0, got}, {20'h0, level});
         waitMode <= 1'b0;
      end
      // Hardware trigger in wait: a channel write alone must not start
      apb(1'b1, `REG_CLKCFG, 32'h0);
      apb(1'b1, `REG_CTRL, 32'ha0);
      waitMode <= 1'b1;
      apb(1'b1, `REG_CHAN, 32'h5);
      apb(1'b0, `REG_STATUS, 32'h0);
      check("no start", {31'h0, rd[1]}, 32'h0);
      hwTrigger <= 1'b1;
      repeat (4) @(posedge clk);
      hwTrigger <= 1'b0;
      waitDone();
      check("trigger flag", {31'h0, rd[0]}, 32'h1);
      // Continuous long-sample conversions in wait: spacing bound
      apb(1'b1, `REG_INT_STATUS, 32'h3);
      apb(1'b1, `REG_INT_MASK, 32'h1);
      apb(1'b1, `REG_CTRL, 32'h3c);
      apb(1'b1, `REG_CHAN, 32'h6);
      waitIrq();
      t = cyc;
      apb(1'b0, `REG_RESULT_LOW, 32'h0);
      apb(1'b1, `REG_INT_STATUS, 32'h1);
      waitIrq();
      t = cyc - t;
      check("continuous", {31'h0, t > 12 && t <= 40}, 32'h1);
      apb(1'b1, `REG_CTRL, 32'h0);
      waitMode <= 1'b0;
      end_of_test();
   end
endmodule
